// file: tb/sdp_link_chk.sv
// assertion checker on the memory link pins
`timescale 1ns/10ps
module sdp_link_chk (
  // clock and reset
  input wire logic                      aclk,
  input wire logic                      aresetn,
  // port control
  input wire logic [sdp_pkg::NPORT-1:0] port_clk,
  input wire logic [sdp_pkg::NPORT-1:0] chip_select_active_low,
  input wire logic [sdp_pkg::NPORT-1:0] chip_select_active_high,
  input wire logic [sdp_pkg::NPORT-1:0] latency_mode_select,
  input wire logic [sdp_pkg::NPORT-1:0] rw_sel,
  input wire logic [sdp_pkg::NPORT-1:0] out_drive_n,
  // data pins
  input wire logic [sdp_pkg::NPORT-1:0] host_dq_oe,
  input wire logic [sdp_pkg::NPORT-1:0] dev_dq_oe,
  input wire logic [sdp_pkg::NPORT-1:0][sdp_pkg::DATA_W-1:0] dev_dq
);
  import sdp_pkg::*;
  // ----------------------
  // port edge bookkeeping
  // ----------------------
  logic [NPORT-1:0] clk_q, clk_d, rd_q, rd_d, rd2_q, rd2_d, edge_w, sel_w;

  always_comb begin
    edge_w = port_clk & ~clk_q;
    sel_w  = ~chip_select_active_low & chip_select_active_high;
    clk_d  = port_clk;
    rd_d   = rd_q;
    rd2_d  = rd2_q;
    for (int i = 0; i < NPORT; i++) begin
      if (edge_w[i]) begin
        rd_d[i]  = sel_w[i] & rw_sel[i];
        rd2_d[i] = rd_q[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_q <= 2'h0;
      rd_q  <= 2'h0;
      rd2_q <= 2'h0;
    end else begin
      clk_q <= clk_d;
      rd_q  <= rd_d;
      rd2_q <= rd2_d;
    end
  end

  // ----------------------
  // per-port properties
  // ----------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    sequence ft_read_s;
      edge_w[p] && sel_w[p] && rw_sel[p] && !latency_mode_select[p]
        && !out_drive_n[p] ##1 !out_drive_n[p];
    endsequence
    chk_ft_read_drive:
      assert property (ft_read_s |=> dev_dq_oe[p])
      else $error("flow-through read not driven");
    chk_oe_drive_gate:
      assert property (out_drive_n[p] |=> !dev_dq_oe[p])
      else $error("data driven with drive enable off");
    chk_no_contention:
      assert property (!(host_dq_oe[p] && dev_dq_oe[p]))
      else $error("both ends drive data");
    chk_ft_oe_cause:
      assert property (dev_dq_oe[p] && !latency_mode_select[p]
                       |-> rd_q[p] || $past(rd_q[p]))
      else $error("flow-through drive without read");
    chk_pipe_oe_cause:
      assert property (dev_dq_oe[p] && latency_mode_select[p]
                       |-> rd2_q[p] || $past(rd2_q[p]))
      else $error("pipelined drive without earlier read");
    chk_dq_edge_cause:
      assert property ($changed(dev_dq[p])
                       |-> $past(edge_w[p]) || $past(edge_w[p], 2))
      else $error("read data moved without port edge");
    chk_desel_hold:
      assert property (edge_w[p] && !sel_w[p] && !latency_mode_select[p]
                       |=> $stable(dev_dq[p]))
      else $error("deselected edge changed read data");
    chk_write_hold:
      assert property (edge_w[p] && sel_w[p] && !rw_sel[p]
                       && !latency_mode_select[p] |=> $stable(dev_dq[p]))
      else $error("write edge changed read data");
  end
endmodule : sdp_link_chk

// file: tb/sync_dual_port_burst_sram_test.sv
// self-checking bench: host and memory joined over the link
`timescale 1ns/10ps
module sync_dual_port_burst_sram_test;
  import sdp_pkg::*;
  localparam logic [ADDR_W-1:0] LAST2  = ADDR_W'(DEPTH - 2);
  localparam logic [ADDR_W-1:0] LAST16 = ADDR_W'(DEPTH - 16);
  // ---------------
  // signals
  // ---------------
  logic             aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic             awready, wready, bvalid, arready, rvalid;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata, d;
  logic [3:0]       wstrb;
  logic [1:0]       bresp, rresp, r;
  logic [NPORT-1:0] awake;
  int               errors, tests_run;

  always #10 aclk = ~aclk;

  sdp_link_if sdp_link_if_i ();
  sdp_host sdp_host_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .link(sdp_link_if_i));
  sdp_ram_dev sdp_ram_dev_i (.aclk(aclk), .aresetn(aresetn),
    .link(sdp_link_if_i), .port_awake(awake));
  sdp_link_chk sdp_link_chk_i (.aclk(aclk), .aresetn(aresetn),
    .port_clk(sdp_link_if_i.port_clk),
    .chip_select_active_low(sdp_link_if_i.chip_select_active_low),
    .chip_select_active_high(sdp_link_if_i.chip_select_active_high),
    .latency_mode_select(sdp_link_if_i.latency_mode_select),
    .rw_sel(sdp_link_if_i.rw_sel), .out_drive_n(sdp_link_if_i.out_drive_n),
    .host_dq_oe(sdp_link_if_i.host_dq_oe),
    .dev_dq_oe(sdp_link_if_i.dev_dq_oe), .dev_dq(sdp_link_if_i.dev_dq));

  // ---------------
  // tasks
  // ---------------
  task automatic print_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                           output logic [1:0] rs);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= v;
    do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] rs);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v  = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    axi_write(a, v, rs);
    check(32'(rs), 32'(RESP_OKAY));
  endtask : reg_wr

  task automatic exp_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  rs;
    axi_read(a, v, rs);
    check(32'(rs), 32'(RESP_OKAY));
    check(v, e);
  endtask : exp_rd

  task automatic wait_idle();
    logic [31:0] s;
    logic [1:0]  rs;
    do axi_read(REG_STATUS, s, rs); while (s[0] !== 1'b0);
  endtask : wait_idle

  task automatic burst(input logic pt, input logic rd, input logic clr,
                       input int len, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] v);
    logic [31:0] cmd;
    cmd = 32'(len - 1) << CMD_LEN;
    cmd[CMD_RD]   = rd;
    cmd[CMD_PORT] = pt;
    cmd[CMD_CLR]  = clr;
    reg_wr(REG_ADDR, 32'(a));
    reg_wr(REG_WDATA, 32'(v));
    reg_wr(REG_CMD, cmd);
    wait_idle();
  endtask : burst

  // ---------------
  // watchdog
  // ---------------
  initial begin
    repeat (30000) @(posedge aclk);
    errors++;
    print_verdict();
  end

  // ---------------
  // main sequence
  // ---------------
  initial begin
    aclk    = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr} = 16'h0000;
    wdata  = 32'h0;
    wstrb  = 4'hf;
    errors = 0;
    tests_run = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(32'(awake), 32'h0);
    exp_rd(REG_STATUS, 32'h0);
    exp_rd(REG_MODE, 32'(MODE_RST));
    axi_read(8'h18, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    axi_write(8'h18, 32'h5, r);
    check(32'(r), 32'(RESP_SLVERR));
    burst(1'b0, 1'b0, 1'b0, 1, 15'h0000, 9'h0a5);
    check(32'(awake), 32'h1);
    burst(1'b0, 1'b0, 1'b0, 2, LAST2, 9'h15a);
    burst(1'b1, 1'b0, 1'b0, 1, 15'h1234, 9'h1c3);
    check(32'(awake), 32'h3);
    for (int m = 0; m < 2; m++) begin
      reg_wr(REG_MODE, (m == 1) ? 32'h3 : 32'h0);
      exp_rd(REG_MODE, (m == 1) ? 32'h3 : 32'h0);
      burst(1'b0, 1'b1, 1'b0, 3, LAST2, 9'h000);
      exp_rd(REG_RDATA, 32'h0a5);
      burst(1'b0, 1'b1, 1'b0, 2, LAST2, 9'h000);
      exp_rd(REG_RDATA, 32'h15a);
      burst(1'b0, 1'b1, 1'b0, 1, 15'h1234, 9'h000);
      exp_rd(REG_RDATA, 32'h1c3);
      burst(1'b1, 1'b1, 1'b1, 1, 15'h1234, 9'h000);
      exp_rd(REG_RDATA, 32'h0a5);
    end
    check(32'(awake), 32'h0);
    reg_wr(REG_MODE, 32'h0);
    burst(1'b1, 1'b0, 1'b1, 2, 15'h1234, 9'h0c3);
    burst(1'b0, 1'b1, 1'b0, 1, 15'h0001, 9'h000);
    exp_rd(REG_RDATA, 32'h0c3);
    reg_wr(REG_ADDR, 32'(LAST16));
    reg_wr(REG_WDATA, 32'h1ee);
    reg_wr(REG_CMD, 32'h0000ff00);
    axi_read(REG_STATUS, d, r);
    check(32'(d[0]), 32'h1);
    reg_wr(REG_MODE, 32'h3);
    wait_idle();
    exp_rd(REG_MODE, 32'h0);
    burst(1'b1, 1'b1, 1'b0, 1, 15'h00ef, 9'h000);
    exp_rd(REG_RDATA, 32'h1ee);
    reg_wr(REG_RDATA, 32'h0);
    exp_rd(REG_RDATA, 32'h1ee);
    print_verdict();
  end
endmodule : sync_dual_port_burst_sram_test

// file: verilog/sdp_host.sv
// host end: axi4-lite registers driving burst accesses
`timescale 1ns/10ps
module sdp_host (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // axi4-lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // memory link
  sdp_link_if.host         link
);
  import sdp_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ---------------
  // state
  // ---------------
  host_state_t                  st_q, st_d;
  logic [1:0]                   ph_q, ph_d;
  logic [LEN_W:0]               beat_q, beat_d, last_q, last_d;
  logic                         rd_q, rd_d, port_q, port_d, clr_q, clr_d;
  logic [LEN_W-1:0]             len_q, len_d;
  logic [ADDR_W-1:0]            addr_q, addr_d;
  logic [DATA_W-1:0]            wdat_q, wdat_d, rdat_q, rdat_d;
  logic [NPORT-1:0]             mode_q, mode_d;
  logic                         awr_q, awr_d, bv_q, bv_d, arr_q, arr_d;
  logic                         rv_q, rv_d;
  logic [1:0]                   br_q, br_d, rr_q, rr_d;
  logic [31:0]                  rd_data_q, rd_data_d, cmd_w, nw;
  logic [NPORT-1:0]             clk_q, clk_d, csl_q, csl_d, csh_q, csh_d;
  logic [NPORT-1:0]             ads_q, ads_d, cen_q, cen_d, ccl_q, ccl_d;
  logic [NPORT-1:0]             rw_q, rw_d, odn_q, odn_d, doe_q, doe_d;
  logic                         first, live;

  always_comb begin
    {st_d, ph_d, beat_d, last_d} = {st_q, ph_q, beat_q, last_q};
    {rd_d, port_d, clr_d, len_d} = {rd_q, port_q, clr_q, len_q};
    {addr_d, wdat_d, rdat_d, mode_d} = {addr_q, wdat_q, rdat_q, mode_q};
    {awr_d, bv_d, arr_d, rv_d} = {awr_q, bv_q, arr_q, rv_q};
    {br_d, rr_d, rd_data_d} = {br_q, rr_q, rd_data_q};
    {clk_d, csl_d, csh_d, ads_d} = {clk_q, csl_q, csh_q, ads_q};
    {cen_d, ccl_d, rw_d, odn_d, doe_d} = {cen_q, ccl_q, rw_q, odn_q, doe_q};
    cmd_w = {16'h0000, len_q, 5'h00, clr_q, port_q, rd_q};
    nw = 32'h0000_0000;
    first = (beat_q == {(LEN_W + 1){1'b0}});
    live = (beat_q <= {1'b0, len_q});
    // bus writes: ready one cycle after both valids
    if (bv_q && bready) begin
      bv_d = 1'b0;
    end
    if (awr_q) begin
      awr_d = 1'b0;
      bv_d = 1'b1;
      br_d = RESP_OKAY;
      if (awaddr == REG_CMD) begin
        nw = merge(cmd_w, wdata, wstrb);
        if (st_q == H_IDLE) begin
          {rd_d, port_d, clr_d} = {nw[CMD_RD], nw[CMD_PORT], nw[CMD_CLR]};
          len_d = nw[CMD_LEN +: LEN_W];
          last_d = {1'b0, len_d}
                 + {{LEN_W{1'b0}}, rd_d & mode_q[port_d]};
          st_d = H_RUN;
          ph_d = PH_DRIVE;
          beat_d = {(LEN_W + 1){1'b0}};
        end
      end else if (awaddr == REG_ADDR) begin
        nw = merge({{(32 - ADDR_W){1'b0}}, addr_q}, wdata, wstrb);
        addr_d = nw[ADDR_W-1:0];
      end else if (awaddr == REG_WDATA) begin
        nw = merge({{(32 - DATA_W){1'b0}}, wdat_q}, wdata, wstrb);
        wdat_d = nw[DATA_W-1:0];
      end else if (awaddr == REG_MODE) begin
        nw = merge({{(32 - NPORT){1'b0}}, mode_q}, wdata, wstrb);
        if (st_q == H_IDLE) begin
          mode_d = nw[NPORT-1:0];
        end
      end else if (awaddr != REG_RDATA && awaddr != REG_STATUS) begin
        br_d = RESP_SLVERR;
      end
    end else if (awvalid && wvalid && !bv_q) begin
      awr_d = 1'b1;
    end
    // bus reads
    if (rv_q && rready) begin
      rv_d = 1'b0;
    end
    if (arr_q) begin
      arr_d = 1'b0;
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      if (araddr == REG_CMD) begin
        rd_data_d = cmd_w;
      end else if (araddr == REG_ADDR) begin
        rd_data_d = {{(32 - ADDR_W){1'b0}}, addr_q};
      end else if (araddr == REG_WDATA) begin
        rd_data_d = {{(32 - DATA_W){1'b0}}, wdat_q};
      end else if (araddr == REG_RDATA) begin
        rd_data_d = {{(32 - DATA_W){1'b0}}, rdat_q};
      end else if (araddr == REG_STATUS) begin
        rd_data_d = {31'h0000_0000, st_q == H_RUN};
      end else if (araddr == REG_MODE) begin
        rd_data_d = {{(32 - NPORT){1'b0}}, mode_q};
      end else begin
        rd_data_d = 32'h0000_0000;
        rr_d = RESP_SLVERR;
      end
    end else if (arvalid && !rv_q) begin
      arr_d = 1'b1;
    end
    // link sequencing, one port at a time
    case (st_q)
      H_IDLE: begin
        ph_d = PH_DRIVE;
      end
      H_RUN: begin
        case (ph_q)
          PH_DRIVE: begin
            csl_d[port_q] = ~live;
            csh_d[port_q] = live;
            ads_d[port_q] = ~(first & ~clr_q);
            ccl_d[port_q] = ~(first & clr_q);
            cen_d[port_q] = ~live;
            rw_d[port_q] = rd_q;
            odn_d[port_q] = ~rd_q;
            doe_d[port_q] = ~rd_q & live;
            ph_d = PH_HIGH;
          end
          PH_HIGH: begin
            clk_d[port_q] = 1'b1;
            ph_d = PH_LOW;
          end
          PH_LOW: begin
            clk_d[port_q] = 1'b0;
            ph_d = PH_SAMPLE;
          end
          default: begin
            if (link.dev_dq_oe[port_q]) begin
              rdat_d = link.dev_dq[port_q];
            end
            beat_d = beat_q + 1'b1;
            ph_d = PH_DRIVE;
            if (beat_q == last_q) begin
              st_d = H_IDLE;
              csl_d = {NPORT{1'b1}};
              csh_d = {NPORT{1'b0}};
              {ads_d, cen_d, ccl_d} = {(3 * NPORT){1'b1}};
              odn_d = {NPORT{1'b1}};
              doe_d = {NPORT{1'b0}};
            end
          end
        endcase
      end
      default: begin
        st_d = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= H_IDLE;
      {ph_q, beat_q, last_q} <= {PH_DRIVE, {(2 * LEN_W + 2){1'b0}}};
      {rd_q, port_q, clr_q, len_q} <= {(3 + LEN_W){1'b0}};
      {addr_q, wdat_q, rdat_q} <= {CNT_RST, DOUT_RST, DOUT_RST};
      mode_q <= MODE_RST;
      {awr_q, bv_q, arr_q, rv_q} <= 4'h0;
      {br_q, rr_q} <= {RESP_OKAY, RESP_OKAY};
      rd_data_q <= 32'h0000_0000;
      {clk_q, csh_q, doe_q} <= {(3 * NPORT){1'b0}};
      {csl_q, ads_q, cen_q, ccl_q} <= {(4 * NPORT){1'b1}};
      {rw_q, odn_q} <= {(2 * NPORT){1'b1}};
    end else begin
      {st_q, ph_q, beat_q, last_q} <= {st_d, ph_d, beat_d, last_d};
      {rd_q, port_q, clr_q, len_q} <= {rd_d, port_d, clr_d, len_d};
      {addr_q, wdat_q, rdat_q, mode_q} <= {addr_d, wdat_d, rdat_d, mode_d};
      {awr_q, bv_q, arr_q, rv_q} <= {awr_d, bv_d, arr_d, rv_d};
      {br_q, rr_q, rd_data_q} <= {br_d, rr_d, rd_data_d};
      {clk_q, csl_q, csh_q, ads_q} <= {clk_d, csl_d, csh_d, ads_d};
      {cen_q, ccl_q, rw_q, odn_q, doe_q} <= {cen_d, ccl_d, rw_d, odn_d, doe_d};
    end
  end

  // ---------------
  // outputs
  // ---------------
  assign {awready, wready, bvalid, bresp} = {awr_q, awr_q, bv_q, br_q};
  assign {arready, rvalid, rdata, rresp} = {arr_q, rv_q, rd_data_q, rr_q};
  assign link.port_clk                = clk_q;
  assign link.chip_select_active_low  = csl_q;
  assign link.chip_select_active_high = csh_q;
  assign link.addr_load_strobe_n      = ads_q;
  assign link.count_advance_n         = cen_q;
  assign link.count_clear_n           = ccl_q;
  assign link.latency_mode_select     = mode_q;
  assign link.rw_sel                  = rw_q;
  assign link.out_drive_n             = odn_q;
  assign link.addr                    = {NPORT{addr_q}};
  assign link.host_dq                 = {NPORT{wdat_q}};
  assign link.host_dq_oe              = doe_q;
endmodule : sdp_host

// file: verilog/sdp_link_if.sv
// pins between the memory ports and their host
`timescale 1ns/10ps
interface sdp_link_if;
  import sdp_pkg::*;
  // ---------------
  // per-port pins
  // ---------------
  logic [NPORT-1:0]             port_clk;
  logic [NPORT-1:0]             chip_select_active_low;
  logic [NPORT-1:0]             chip_select_active_high;
  logic [NPORT-1:0]             addr_load_strobe_n;
  logic [NPORT-1:0]             count_advance_n;
  logic [NPORT-1:0]             count_clear_n;
  logic [NPORT-1:0]             latency_mode_select;
  logic [NPORT-1:0]             rw_sel;
  logic [NPORT-1:0]             out_drive_n;
  logic [NPORT-1:0][ADDR_W-1:0] addr;
  // ---------------
  // data pins
  // ---------------
  logic [NPORT-1:0][DATA_W-1:0] host_dq;
  logic [NPORT-1:0]             host_dq_oe;
  logic [NPORT-1:0][DATA_W-1:0] dev_dq;
  logic [NPORT-1:0]             dev_dq_oe;

  modport device (
    input  port_clk, chip_select_active_low, chip_select_active_high,
    input  addr_load_strobe_n, count_advance_n, count_clear_n,
    input  latency_mode_select, rw_sel, out_drive_n, addr,
    input  host_dq, host_dq_oe,
    output dev_dq, dev_dq_oe
  );
  modport host (
    output port_clk, chip_select_active_low, chip_select_active_high,
    output addr_load_strobe_n, count_advance_n, count_clear_n,
    output latency_mode_select, rw_sel, out_drive_n, addr,
    output host_dq, host_dq_oe,
    input  dev_dq, dev_dq_oe
  );
endinterface : sdp_link_if

// file: verilog/sdp_pkg.sv
// shared constants for the dual-port burst memory and its host
package sdp_pkg;
  // ---------------
  // array and ports
  // ---------------
  // address width 15/16/17 gives 32K/64K/128K words
  localparam int ADDR_W = 15;
  // word width 8 or 9
  localparam int DATA_W = 9;
  localparam int DEPTH  = 1 << ADDR_W;
  localparam int NPORT  = 2;
  localparam logic [ADDR_W-1:0] CNT_RST  = {ADDR_W{1'b0}};
  localparam logic [DATA_W-1:0] DOUT_RST = {DATA_W{1'b0}};

  // ------------------
  // host register map
  // ------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_MODE   = 8'h14;
  localparam int CMD_RD   = 0;
  localparam int CMD_PORT = 1;
  localparam int CMD_CLR  = 2;
  localparam int CMD_LEN  = 8;
  localparam int LEN_W    = 8;
  localparam logic [NPORT-1:0] MODE_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------
  // host beat phases
  // ------------------
  localparam logic [1:0] PH_DRIVE  = 2'h0;
  localparam logic [1:0] PH_HIGH   = 2'h1;
  localparam logic [1:0] PH_LOW    = 2'h2;
  localparam logic [1:0] PH_SAMPLE = 2'h3;

  typedef enum logic {H_IDLE, H_RUN} host_state_t;
endpackage : sdp_pkg

// file: verilog/sdp_ram_dev.sv
// dual-port burst memory, device end of the link
`timescale 1ns/10ps
// How it works
// - array size and word width from package
// - two ports access any word independently
// - host avoids same-word writes on both ports
// - port inputs captured on own clock edge
// - pipelined adds output stage, flow-through bypasses
// - mode select low flow-through, high pipelined
// - either chip select inactive deselects port
// - pipelined outputs return one cycle after select
// - load strobe low uses and loads address
// - count advance low increments counter each edge
// - load or clear overrides count advance
// - counter wraps from last word to zero
// - clear low zeroes counter unconditionally
// - data driven on reads only with enable low
// - select low writes, high reads
// - write completes within the single cycle
// - port clock may run free or strobed
// - drive enable direct, rest sampled at edge
// - pipelined read data one cycle later
// - load strobe high uses counter as address
// - counter works regardless of chip selects
module sdp_ram_dev (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // memory link
  sdp_link_if.device                     link,
  // port power state
  output logic [sdp_pkg::NPORT-1:0]      port_awake
);
  import sdp_pkg::*;

  // ---------------
  // storage
  // ---------------
  logic [DATA_W-1:0]            mem [DEPTH];
  logic [NPORT-1:0]             we;
  logic [NPORT-1:0][ADDR_W-1:0] wa;
  logic [NPORT-1:0][DATA_W-1:0] wd;
  logic [NPORT-1:0][DATA_W-1:0] dout;
  logic [NPORT-1:0]             oe;
  logic [NPORT-1:0]             awake;

  // ---------------
  // port logic
  // ---------------
  genvar p;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      logic              clk_prev_q;
      logic              clk_prev_d;
      logic              edge_seen;
      logic              sel;
      logic              rd;
      logic [ADDR_W-1:0] cnt_q;
      logic [ADDR_W-1:0] cnt_d;
      logic [DATA_W-1:0] stage_q;
      logic [DATA_W-1:0] stage_d;
      logic [DATA_W-1:0] dout_q;
      logic [DATA_W-1:0] dout_d;
      logic              rd_act_q;
      logic              rd_act_d;
      logic              pipe_act_q;
      logic              pipe_act_d;
      logic              oe_q;
      logic              oe_d;
      logic              sel_q;
      logic              sel_d;

      always_comb begin
        // edge of the port clock, free running or strobed
        edge_seen = link.port_clk[p] & ~clk_prev_q;
        clk_prev_d = link.port_clk[p];
        sel = ~link.chip_select_active_low[p]
            & link.chip_select_active_high[p];
        rd = sel & link.rw_sel[p];
        cnt_d = cnt_q;
        stage_d = stage_q;
        dout_d = dout_q;
        rd_act_d = rd_act_q;
        pipe_act_d = pipe_act_q;
        sel_d = sel_q;
        if (edge_seen) begin
          // counter ignores the chip selects
          if (!link.count_clear_n[p]) begin
            cnt_d = CNT_RST;
          end else if (!link.addr_load_strobe_n[p]) begin
            cnt_d = link.addr[p];
          end else if (!link.count_advance_n[p]) begin
            cnt_d = cnt_q + 1'b1;
          end
          // counter value is the access address
          sel_d = sel;
          rd_act_d = rd;
          pipe_act_d = rd_act_q;
          if (link.latency_mode_select[p]) begin
            // pipelined: extra output stage
            if (rd) begin
              stage_d = mem[cnt_d];
            end
            dout_d = stage_q;
          end else if (rd) begin
            // flow-through: no output stage
            dout_d = mem[cnt_d];
          end
        end
        // deselected flow-through port holds its data, memory not read
        // enable follows this edge's read state (flow-through) or the prior edge's (pipelined), level with the data
        oe_d = ~link.out_drive_n[p]
             & (link.latency_mode_select[p] ? pipe_act_d
                                            : rd_act_d);
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          clk_prev_q <= 1'b0;
          cnt_q      <= CNT_RST;
          stage_q    <= DOUT_RST;
          dout_q     <= DOUT_RST;
          rd_act_q   <= 1'b0;
          pipe_act_q <= 1'b0;
          oe_q       <= 1'b0;
          sel_q      <= 1'b0;
        end else begin
          clk_prev_q <= clk_prev_d;
          cnt_q      <= cnt_d;
          stage_q    <= stage_d;
          dout_q     <= dout_d;
          rd_act_q   <= rd_act_d;
          pipe_act_q <= pipe_act_d;
          oe_q       <= oe_d;
          sel_q      <= sel_d;
        end
      end

      // write is done within the edge cycle
      assign we[p]    = edge_seen & sel & ~link.rw_sel[p];
      assign wa[p]    = cnt_d;
      assign wd[p]    = link.host_dq[p];
      assign dout[p]  = dout_q;
      assign oe[p]    = oe_q;
      assign awake[p] = sel_q;
    end
  endgenerate

  // ---------------
  // array writes
  // ---------------
  // both ports may write in one cycle; higher port wins a collision
  always_ff @(posedge aclk) begin
    for (int i = 0; i < NPORT; i++) begin
      if (we[i]) begin
        mem[wa[i]] <= wd[i];
      end
    end
  end

  // ---------------
  // outputs
  // ---------------
  assign link.dev_dq    = dout;
  assign link.dev_dq_oe = oe;
  assign port_awake     = awake;
endmodule : sdp_ram_dev
